// ### rtl/vga_sync_timing_generator.sv
// Purpose: Line and frame timing for a 640x480 monitor with a pixel FIFO.
// Assumes: Pixel source fills the FIFO ahead of the visible area.
// Notes: An empty FIFO in the visible area shows black, not stale data.
`timescale 1ns/1ps

module pixel_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             in_ready_r;
  wire              push = in_valid && in_ready_r;
  wire              pop  = out_valid && out_ready;

  assign out_valid = (count_r != '0);
  assign out_data  = mem[rd_ptr_r];
  assign in_ready  = in_ready_r;
  assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);

  // Ready is registered so the top port comes from a flop; it therefore
  // looks one cycle ahead at the count that the next edge will hold.
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r   <= '0;
      rd_ptr_r   <= '0;
      count_r    <= '0;
      in_ready_r <= 1'b1;
    end else begin
      wr_ptr_r   <= push ? wr_ptr_r + 1'b1 : wr_ptr_r;
      rd_ptr_r   <= pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
      count_r    <= count_nxt;
      in_ready_r <= (count_nxt != (AW+1)'(DEPTH));
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  a_fifo_no_overflow: assert property (
    @(posedge clk) disable iff (rst)
    count_r <= (AW+1)'(DEPTH))
    else $error("FIFO count above depth.");

  a_fifo_ready_level: assert property (
    @(posedge clk) disable iff (rst)
    in_ready == (count_r != (AW+1)'(DEPTH)))
    else $error("FIFO ready disagrees with fill level.");

  a_fifo_full_hold: assert property (
    @(posedge clk) disable iff (rst)
    in_valid && !in_ready |=> wr_ptr_r == $past(wr_ptr_r))
    else $error("FIFO took a word while full.");

  a_fifo_empty_hold: assert property (
    @(posedge clk) disable iff (rst)
    !out_valid |=> rd_ptr_r == $past(rd_ptr_r))
    else $error("FIFO read pointer moved while empty.");

endmodule : pixel_fifo

module vga_sync_timing_generator #(
  parameter int FIFO_DEPTH = vga_timing_pkg::FIFO_DEPTH
) (
  input  wire logic                      MCLK,
  input  wire logic                      SYS_RST,
  input  wire vga_timing_pkg::pixel_t    PIX_DATA,
  input  wire logic                      PIX_VALID,
  output logic                           PIX_READY,
  output logic [9:0]                     PIX_COL,
  output logic [9:0]                     PIX_ROW,
  output logic                           PIX_ACTIVE,
  output logic [3:0]                     RED,
  output logic [3:0]                     GREEN,
  output logic [3:0]                     BLUE,
  output logic                           LINE_SYNC_OUT,
  output logic                           FRAME_SYNC_OUT
);
  logic [9:0]             h_r;
  logic [9:0]             v_r;
  logic [9:0]             col_r;
  logic [9:0]             row_r;
  logic                   active_r;
  logic                   line_sync_r;
  logic                   frame_sync_r;
  vga_timing_pkg::pixel_t color_r;
  logic [11:0]            fifo_q;
  logic                   fifo_valid;

  wire h_last   = (h_r == vga_timing_pkg::H_TOTAL - 10'h001);
  wire v_last   = (v_r == vga_timing_pkg::V_TOTAL - 10'h001);
  wire [9:0] h_nxt = h_last ? 10'h000 : h_r + 10'h001;
  wire [9:0] v_nxt = !h_last ? v_r : (v_last ? 10'h000 : v_r + 10'h001);
  wire h_in_sync = (h_r < vga_timing_pkg::H_SYNC_CYC);
  wire v_in_sync = (v_r < vga_timing_pkg::V_SYNC_LINES);
  wire h_disp   = (h_r >= vga_timing_pkg::H_DISP_START) &&
                  (h_r <  vga_timing_pkg::H_DISP_END);
  wire v_disp   = (v_r >= vga_timing_pkg::V_DISP_START) &&
                  (v_r <  vga_timing_pkg::V_DISP_END);
  wire in_view  = h_disp && v_disp;
  wire [9:0] col_nxt = in_view ? h_r - vga_timing_pkg::H_DISP_START : '0;
  wire [9:0] row_nxt = v_disp ? v_r - vga_timing_pkg::V_DISP_START : '0;
  wire vga_timing_pkg::pixel_t color_nxt =
    (in_view && fifo_valid) ? vga_timing_pkg::pixel_t'(fifo_q)
                            : vga_timing_pkg::PIXEL_BLACK;

  // Pixels are pulled strictly in scan order, one per visible clock.
  pixel_fifo #(
    .WIDTH ($bits(vga_timing_pkg::pixel_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (MCLK),
    .rst       (SYS_RST),
    .in_data   (PIX_DATA),
    .in_valid  (PIX_VALID),
    .in_ready  (PIX_READY),
    .out_data  (fifo_q),
    .out_valid (fifo_valid),
    .out_ready (in_view)
  );

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      h_r <= '0;
      v_r <= '0;
    end else begin
      h_r <= h_nxt;
      v_r <= v_nxt;
    end
  end

  // All outputs except PIX_READY share one register stage so sync and colour stay aligned.
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      line_sync_r  <= 1'b1;
      frame_sync_r <= 1'b1;
      color_r      <= vga_timing_pkg::PIXEL_BLACK;
      col_r        <= '0;
      row_r        <= '0;
      active_r     <= 1'b0;
    end else begin
      line_sync_r  <= !h_in_sync;
      frame_sync_r <= !v_in_sync;
      color_r      <= color_nxt;
      col_r        <= col_nxt;
      row_r        <= row_nxt;
      active_r     <= in_view;
    end
  end

  assign LINE_SYNC_OUT  = line_sync_r;
  assign FRAME_SYNC_OUT = frame_sync_r;
  assign RED            = color_r.red;
  assign GREEN          = color_r.green;
  assign BLUE           = color_r.blue;
  assign PIX_COL        = col_r;
  assign PIX_ROW        = row_r;
  assign PIX_ACTIVE     = active_r;

  // Helper counters measure sync widths and blank gaps for the checks.
  logic [9:0] hs_low_r;
  logic [9:0] vs_low_r;
  logic [9:0] dark_run_r;
  logic       post_act_r;
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      hs_low_r   <= '0;
      vs_low_r   <= '0;
      dark_run_r <= '0;
      post_act_r <= 1'b0;
    end else begin
      hs_low_r   <= !LINE_SYNC_OUT ? hs_low_r + 10'h001 : '0;
      vs_low_r   <= (!FRAME_SYNC_OUT && h_last) ? vs_low_r + 10'h001
                  : (FRAME_SYNC_OUT ? 10'h000 : vs_low_r);
      dark_run_r <= (PIX_ACTIVE || !LINE_SYNC_OUT) ? 10'h000
                  : dark_run_r + 10'h001;
      post_act_r <= PIX_ACTIVE || (post_act_r && LINE_SYNC_OUT);
    end
  end

  a_line_sync_width: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    $rose(LINE_SYNC_OUT) |-> hs_low_r == vga_timing_pkg::H_SYNC_CYC)
    else $error("Line sync pulse width wrong.");

  a_frame_sync_lines: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    $rose(FRAME_SYNC_OUT) |-> vs_low_r == vga_timing_pkg::V_SYNC_LINES)
    else $error("Frame sync pulse not two lines.");

  a_back_porch_dark: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    $rose(LINE_SYNC_OUT) |-> (!PIX_ACTIVE && color_r == '0) [*8])
    else $error("Colour not dark after line sync.");

  a_back_porch_len: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    $rose(PIX_ACTIVE) |-> dark_run_r == vga_timing_pkg::H_BACK_CYC)
    else $error("Back porch length wrong.");

  a_active_start: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    $rose(PIX_ACTIVE) |->
      PIX_COL == 10'h000 && $past(h_r) == vga_timing_pkg::H_DISP_START)
    else $error("Active area starts at wrong clock.");

  a_active_end: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    $fell(PIX_ACTIVE) |->
      $past(PIX_COL) == vga_timing_pkg::H_ACTIVE - 10'h001)
    else $error("Active area ends at wrong column.");

  a_col_advance: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    PIX_ACTIVE && $past(PIX_ACTIVE) |-> PIX_COL == $past(PIX_COL) + 10'h001)
    else $error("Column did not advance by one.");

  a_underrun_black: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    in_view && !fifo_valid |=> color_r == vga_timing_pkg::PIXEL_BLACK)
    else $error("Empty FIFO did not show black.");

  a_front_porch_dark: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    $fell(PIX_ACTIVE) |-> (color_r == '0 && LINE_SYNC_OUT) [*8])
    else $error("Front porch not dark.");

  a_front_porch_len: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    $fell(LINE_SYNC_OUT) && post_act_r |->
      dark_run_r == vga_timing_pkg::H_FRONT_CYC)
    else $error("Front porch length wrong.");

  a_dark_outside: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    !PIX_ACTIVE |-> RED == '0 && GREEN == '0 && BLUE == '0)
    else $error("Colour driven outside active area.");

  a_sync_in_blank: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    !LINE_SYNC_OUT |-> !PIX_ACTIVE && color_r == '0)
    else $error("Colour shown during line sync.");

  a_row_range: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    PIX_ACTIVE |-> PIX_ROW < vga_timing_pkg::V_ACTIVE
                   && PIX_COL < vga_timing_pkg::H_ACTIVE)
    else $error("Active pixel outside 640x480.");

  a_row_steady: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    PIX_ACTIVE && $past(PIX_ACTIVE) |-> $stable(PIX_ROW))
    else $error("Row changed inside a line.");

  a_counter_wrap: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    h_last && v_last |=> h_r == 10'h000 && v_r == 10'h000)
    else $error("Frame counters did not wrap.");

  a_line_wrap: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    h_last |=> h_r == 10'h000)
    else $error("Pixel counter did not wrap.");

  a_pixel_step: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    !h_last |=> h_r == $past(h_r) + 10'h001)
    else $error("Pixel counter did not step by one.");

  a_line_hold: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    !h_last |=> $stable(v_r))
    else $error("Line counter moved inside a line.");

  a_frame_on_line: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    $changed(FRAME_SYNC_OUT) |-> $fell(LINE_SYNC_OUT))
    else $error("Frame sync moved away from a line start.");

  a_sync_idle_high: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    PIX_ACTIVE |-> LINE_SYNC_OUT && FRAME_SYNC_OUT)
    else $error("Sync low during active area.");

  a_blank_col_zero: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    !PIX_ACTIVE |-> PIX_COL == 10'h000)
    else $error("Column not zero while blank.");

endmodule : vga_sync_timing_generator

// ### rtl/vga_timing_pkg.sv
// Purpose: Shared constants and types for the display timing generator.
// Assumes: One clock, MCLK, at 20 MHz; one active pixel per clock.
// Notes: Horizontal porch and sync counts come from the times and the clock period.
package vga_timing_pkg;

  localparam int CLK_PERIOD_NS = 50;

  localparam int H_SYNC_NS  = 3800;
  localparam int H_BACK_NS  = 1900;
  localparam int H_FRONT_NS = 600;

  localparam logic [9:0] H_SYNC_CYC  =
    10'((H_SYNC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] H_BACK_CYC  =
    10'((H_BACK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] H_FRONT_CYC =
    10'((H_FRONT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] H_ACTIVE    = 10'h280;

  localparam logic [9:0] H_DISP_START = H_SYNC_CYC + H_BACK_CYC;
  localparam logic [9:0] H_DISP_END   = H_DISP_START + H_ACTIVE;
  localparam logic [9:0] H_TOTAL      = H_DISP_END + H_FRONT_CYC;

  localparam logic [9:0] V_SYNC_LINES  = 10'h002;
  localparam logic [9:0] V_BACK_LINES  = 10'h021;
  localparam logic [9:0] V_ACTIVE      = 10'h1e0;
  localparam logic [9:0] V_FRONT_LINES = 10'h00a;

  localparam logic [9:0] V_DISP_START = V_SYNC_LINES + V_BACK_LINES;
  localparam logic [9:0] V_DISP_END   = V_DISP_START + V_ACTIVE;
  localparam logic [9:0] V_TOTAL      = V_DISP_END + V_FRONT_LINES;

  localparam int FIFO_DEPTH = 32;
  localparam int COLOR_W    = 4;

  typedef struct packed {
    logic [COLOR_W-1:0] red;
    logic [COLOR_W-1:0] green;
    logic [COLOR_W-1:0] blue;
  } pixel_t;

  localparam pixel_t PIXEL_BLACK = '0;

endpackage : vga_timing_pkg

// ### dv/vga_monitor_model.sv
// Purpose: Monitor-side model that measures sync and colour timing.
// Assumes: Samples the design outputs on the rising pixel clock.
// Notes: Holds the last complete measurement of each interval.
`timescale 1ns/1ps
module vga_monitor_model (
  input  wire logic        clk,
  input  wire logic        hs,
  input  wire logic        vs,
  input  wire logic        act,
  input  wire logic [11:0] rgb,
  output int               hs_low,
  output int               vs_low,
  output int               line_len,
  output int               act_len,
  output int               line_idx,
  output int               blank_bad
);
  int   hs_run, vs_run, cnt, act_run;
  logic hs_q = 1'b1;
  logic vs_q = 1'b1;
  // A real monitor cannot stall, so this model only watches.
  always @(posedge clk) begin
    if (hs === 1'b0) hs_run++;
    else begin if (hs_run > 0) hs_low = hs_run; hs_run = 0; end
    if (vs === 1'b0) vs_run++;
    else begin if (vs_run > 0) vs_low = vs_run; vs_run = 0; end
    if (act === 1'b1) act_run++;
    if (act === 1'b0 && rgb !== 12'h000) blank_bad++;
    if (hs_q === 1'b1 && hs === 1'b0) begin
      line_len = cnt;
      cnt = 1;
      act_len = act_run;
      act_run = 0;
      line_idx = (vs_q === 1'b1 && vs === 1'b0) ? 0 : line_idx + 1;
    end else cnt++;
    hs_q = hs;
    vs_q = vs;
  end
endmodule : vga_monitor_model

// ### dv/testbench.sv
// Purpose: Self-checking bench for the display timing generator.
// Assumes: Outputs are sampled on the falling clock, after they settle.
// Notes: One frame is too long to run, so only its first lines are seen.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  logic MCLK = 1'b0, SYS_RST = 1'b1, PIX_VALID = 1'b0;
  vga_timing_pkg::pixel_t PIX_DATA = '0;
  logic       PIX_READY, PIX_ACTIVE, LINE_SYNC_OUT, FRAME_SYNC_OUT;
  logic [9:0] PIX_COL, PIX_ROW;
  logic [3:0] RED, GREEN, BLUE;
  int error_cnt, num_checks, hs_low, vs_low, line_len, act_len;
  int line_idx, blank_bad, k;
  vga_sync_timing_generator #(.FIFO_DEPTH(32)) i_dut (.MCLK, .SYS_RST,
    .PIX_DATA, .PIX_VALID, .PIX_READY, .PIX_COL, .PIX_ROW, .PIX_ACTIVE,
    .RED, .GREEN, .BLUE, .LINE_SYNC_OUT, .FRAME_SYNC_OUT);
  vga_monitor_model i_mon (.clk(MCLK), .hs(LINE_SYNC_OUT),
    .vs(FRAME_SYNC_OUT), .act(PIX_ACTIVE), .rgb({RED, GREEN, BLUE}),
    .hs_low, .vs_low, .line_len, .act_len, .line_idx, .blank_bad);
  function automatic logic [11:0] pix(int i);
    return 12'(i * 37 + 5);
  endfunction : pix
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic t_reset;
    @(posedge MCLK);
    @(negedge MCLK);
    `CHK("sync idle", 2'b11, {LINE_SYNC_OUT, FRAME_SYNC_OUT})
    `CHK("colour reset", 12'h000, {RED, GREEN, BLUE})
    `CHK("ready reset", 1'b1, PIX_READY)
    @(posedge MCLK) SYS_RST <= 1'b0;
    @(posedge MCLK);
    @(negedge MCLK);
    `CHK("sync start", 2'b00, {LINE_SYNC_OUT, FRAME_SYNC_OUT})
    $display("t_reset done");
  endtask : t_reset
  // Fill until the FIFO refuses; the word still offered must not enter.
  task automatic t_fill;
    k = 0;
    @(posedge MCLK);
    PIX_VALID <= 1'b1;
    PIX_DATA <= pix(0);
    repeat (40) begin
      @(negedge MCLK);
      if (PIX_READY !== 1'b1) break;
      @(posedge MCLK);
      k++;
      PIX_DATA <= pix(k);
    end
    `CHK("words taken", 32, k)
    repeat (3) @(posedge MCLK);
    PIX_VALID <= 1'b0;
    $display("t_fill done");
  endtask : t_fill
  task automatic t_timing;
    repeat (3000) @(posedge MCLK);
    @(negedge MCLK);
    `CHK("line sync low", 76, hs_low)
    `CHK("line length", 766, line_len)
    `CHK("frame sync low", 1532, vs_low)
    $display("t_timing done");
  endtask : t_timing
  task automatic t_active;
    k = 0;
    while (PIX_ACTIVE !== 1'b1 && k < 30000) begin
      @(negedge MCLK);
      k++;
    end
    `CHK("first line", 35, line_idx)
    `CHK("row", 10'h000, PIX_ROW)
    for (int i = 0; i < 36; i++) begin
      `CHK("col", 10'(i), PIX_COL)
      `CHK("pixel", (i < 32) ? pix(i) : 12'h000, {RED, GREEN, BLUE})
      @(negedge MCLK);
    end
    repeat (730) @(negedge MCLK);
    `CHK("next row", 10'h001, PIX_ROW)
    `CHK("next col", 10'h000, PIX_COL)
    `CHK("active count", 640, act_len)
    `CHK("blank colour", 0, blank_bad)
    $display("t_active done");
  endtask : t_active
  // A reset right after a visible line starts, at column 1, must restart both counters.
  task automatic t_rereset;
    @(posedge MCLK) SYS_RST <= 1'b1;
    repeat (2) @(posedge MCLK);
    @(negedge MCLK);
    `CHK("reset active", 1'b0, PIX_ACTIVE)
    `CHK("reset colour", 12'h000, {RED, GREEN, BLUE})
    `CHK("reset sync", 2'b11, {LINE_SYNC_OUT, FRAME_SYNC_OUT})
    @(posedge MCLK) SYS_RST <= 1'b0;
    @(posedge MCLK);
    @(negedge MCLK);
    `CHK("restart sync", 2'b00, {LINE_SYNC_OUT, FRAME_SYNC_OUT})
    $display("t_rereset done");
  endtask : t_rereset
  initial begin
    forever #25 MCLK = ~MCLK;
  end
  initial begin
    #3000000;
    error_cnt++;
    final_report();
  end
  initial begin
    t_reset();
    t_fill();
    t_timing();
    t_active();
    t_rereset();
    final_report();
  end
endmodule : testbench
